// ### core/pmd_map.svh
// Register offsets, field positions, reset values and timing counts for the module disable registers.
`ifndef PMD_MAP_SVH
`define PMD_MAP_SVH

`define PMD_ADDR_W          12
`define PMD_OFF_CTRL_A      12'h000
`define PMD_OFF_CTRL_B      12'h004
`define PMD_BIT_COMPARATOR  10
`define PMD_BIT_CRC         7
`define PMD_BIT_I2C2        1
`define PMD_BIT_REFCLK      3
`define PMD_BIT_CHARGE      2
`define PMD_MASK_A          16'h0482
`define PMD_MASK_B          16'h000c
`define PMD_RESET_A         16'h0000
`define PMD_RESET_B         16'h0000
`define PMD_HOLD_NS         40
`define PMD_CLK_NS          20
`define PMD_HOLD_CYCLES     ((`PMD_HOLD_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)

`endif

// ### core/pmd_pkg.sv
// Types shared by the module disable register bank.
`default_nettype none
package pmd_pkg;

    typedef logic [15:0] pmd_word_t;

    typedef struct packed {
        pmd_word_t   ctrl_a;
        pmd_word_t   ctrl_b;
        logic [31:0] prdata;
    } pmd_state_s;

endpackage : pmd_pkg

`default_nettype wire

// ### core/pmd_regs.sv
// APB register bank whose bits switch individual peripherals off.
//
// Operation
// - Control A bit 10 disables comparator.
// - Control A bit 7 disables CRC engine.
// - Control A bit 1 disables second I2C.
// - Control B bit 3 disables reference clock.
// - Control B bit 2 disables charge-time unit.
// - Other control A bits ignore writes, read zero.
// - Other control B bits ignore writes, read zero.
// - Implemented bits read/write, reset to zero.
//
// Chosen here: the address map and the APB register port.
`include "pmd_map.svh"
`timescale 1ns/1ns
`default_nettype none

module pmd_regs
    import pmd_pkg::*;
(
    // Clock and reset.
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave.
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`PMD_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Peripheral disable levels.
    output logic                         comparator_off,
    output logic                         crc_engine_off,
    output logic                         second_i2c_off,
    output logic                         ref_clock_out_off,
    output logic                         charge_time_unit_off,
    // Peripheral clock enables, low while the peripheral is disabled.
    output logic                         comparator_clk_en,
    output logic                         crc_engine_clk_en,
    output logic                         second_i2c_clk_en,
    output logic                         ref_clock_out_clk_en,
    output logic                         charge_time_unit_clk_en,
    // Peripheral resets, active low, held while the peripheral is disabled.
    output logic                         comparator_rst_n,
    output logic                         crc_engine_rst_n,
    output logic                         second_i2c_rst_n,
    output logic                         ref_clock_out_rst_n,
    output logic                         charge_time_unit_rst_n
);

    pmd_state_s state;
    pmd_state_s next_state;

    function automatic pmd_word_t merge_write(input pmd_word_t old, input logic [31:0] data,
                                              input logic [3:0] strb, input pmd_word_t mask);
        pmd_word_t merged;
        merged = old;
        if (strb[0])
        begin
            merged[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            merged[15:8] = data[15:8];
        end
        merge_write = merged & mask;
    endfunction : merge_write

    function automatic logic addr_match(input logic [`PMD_ADDR_W-1:0] addr,
                                        input logic [`PMD_ADDR_W-1:0] offset);
        addr_match = (addr == offset);
    endfunction : addr_match

    function automatic logic [31:0] read_word(input pmd_word_t value, input pmd_word_t mask);
        read_word = {16'h0000, value & mask};
    endfunction : read_word

    logic access;
    logic hit_a;
    logic hit_b;

    assign access = psel && penable;
    assign hit_a  = addr_match(paddr, `PMD_OFF_CTRL_A);
    assign hit_b  = addr_match(paddr, `PMD_OFF_CTRL_B);

    always_comb
    begin
        next_state = state;
        if (access && pwrite && hit_a)
        begin
            next_state.ctrl_a = merge_write(state.ctrl_a, pwdata, pstrb, `PMD_MASK_A);
        end
        if (access && pwrite && hit_b)
        begin
            next_state.ctrl_b = merge_write(state.ctrl_b, pwdata, pstrb, `PMD_MASK_B);
        end
        if (psel && !penable && !pwrite)
        begin
            next_state.prdata = 32'h0000_0000;
            if (hit_a)
            begin
                next_state.prdata = read_word(state.ctrl_a, `PMD_MASK_A);
            end
            else if (hit_b)
            begin
                next_state.prdata = read_word(state.ctrl_b, `PMD_MASK_B);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state.ctrl_a <= `PMD_RESET_A;
            state.ctrl_b <= `PMD_RESET_B;
            state.prdata <= 32'h0000_0000;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign prdata  = state.prdata;
    assign pready  = 1'b1;
    assign pslverr = access && !(hit_a || hit_b);

    assign comparator_off       = state.ctrl_a[`PMD_BIT_COMPARATOR];
    assign crc_engine_off       = state.ctrl_a[`PMD_BIT_CRC];
    assign second_i2c_off       = state.ctrl_a[`PMD_BIT_I2C2];
    assign ref_clock_out_off    = state.ctrl_b[`PMD_BIT_REFCLK];
    assign charge_time_unit_off = state.ctrl_b[`PMD_BIT_CHARGE];

    assign comparator_clk_en       = !comparator_off;
    assign crc_engine_clk_en       = !crc_engine_off;
    assign second_i2c_clk_en       = !second_i2c_off;
    assign ref_clock_out_clk_en    = !ref_clock_out_off;
    assign charge_time_unit_clk_en = !charge_time_unit_off;

    assign comparator_rst_n       = presetn && !comparator_off;
    assign crc_engine_rst_n       = presetn && !crc_engine_off;
    assign second_i2c_rst_n       = presetn && !second_i2c_off;
    assign ref_clock_out_rst_n    = presetn && !ref_clock_out_off;
    assign charge_time_unit_rst_n = presetn && !charge_time_unit_off;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence write_a_s;
        psel && penable && pwrite && hit_a && pstrb[1];
    endsequence

    sequence write_a0_s;
        psel && penable && pwrite && hit_a && pstrb[0];
    endsequence

    sequence write_b0_s;
        psel && penable && pwrite && hit_b && pstrb[0];
    endsequence

    sequence write_stray_s;
        psel && penable && pwrite && !(hit_a || hit_b);
    endsequence

    sequence read_a_setup_s;
        psel && !penable && !pwrite && hit_a;
    endsequence

    sequence read_b_setup_s;
        psel && !penable && !pwrite && hit_b;
    endsequence

    cmp_follow_a: assert property (write_a_s |=> comparator_off == $past(pwdata[10]))
        else $error("comparator disable does not follow write");
    crc_follow_a: assert property (write_a0_s |=> crc_engine_off == $past(pwdata[7]))
        else $error("crc disable does not follow write");
    i2c_follow_a: assert property (write_a0_s |=> second_i2c_off == $past(pwdata[1]))
        else $error("i2c disable does not follow write");
    refclk_follow_a: assert property (write_b0_s |=> ref_clock_out_off == $past(pwdata[3]))
        else $error("reference clock disable does not follow write");
    charge_follow_a: assert property (write_b0_s |=> charge_time_unit_off == $past(pwdata[2]))
        else $error("charge unit disable does not follow write");

    unused_a_zero_a: assert property ((state.ctrl_a & ~`PMD_MASK_A) == 16'h0000)
        else $error("unimplemented control A bit set");
    unused_b_zero_a: assert property ((state.ctrl_b & ~`PMD_MASK_B) == 16'h0000)
        else $error("unimplemented control B bit set");
    read_back_a: assert property (read_a_setup_s |=> prdata == {16'h0000, $past(state.ctrl_a)})
        else $error("control A read does not return stored value");
    read_back_b_a: assert property (read_b_setup_s |=> prdata == {16'h0000, $past(state.ctrl_b)})
        else $error("control B read does not return stored value");
    upper_zero_a: assert property (prdata[31:16] == 16'h0000)
        else $error("upper read data bits not zero");

    idle_hold_a: assert property (crc_engine_off |-> !crc_engine_clk_en && !crc_engine_rst_n)
        else $error("disabled crc engine not held idle");
    cmp_idle_a: assert property (comparator_off |-> !comparator_clk_en && !comparator_rst_n)
        else $error("disabled comparator not held idle");
    i2c_idle_a: assert property (second_i2c_off |-> !second_i2c_clk_en && !second_i2c_rst_n)
        else $error("disabled i2c controller not held idle");
    refclk_idle_a: assert property (ref_clock_out_off |-> !ref_clock_out_clk_en && !ref_clock_out_rst_n)
        else $error("disabled reference clock not held idle");
    charge_idle_a: assert property (charge_time_unit_off |-> !charge_time_unit_clk_en && !charge_time_unit_rst_n)
        else $error("disabled charge unit not held idle");
    cmp_restart_a: assert property (!comparator_off |-> comparator_clk_en && comparator_rst_n)
        else $error("enabled comparator not running");
    crc_restart_a: assert property (!crc_engine_off |-> crc_engine_clk_en && crc_engine_rst_n)
        else $error("enabled crc engine not running");
    i2c_restart_a: assert property (!second_i2c_off |-> second_i2c_clk_en && second_i2c_rst_n)
        else $error("enabled i2c controller not running");
    refclk_restart_a: assert property (!ref_clock_out_off |-> ref_clock_out_clk_en && ref_clock_out_rst_n)
        else $error("enabled reference clock not running");
    charge_restart_a: assert property (!charge_time_unit_off |-> charge_time_unit_clk_en && charge_time_unit_rst_n)
        else $error("enabled charge unit not running");

    stable_nowrite_a: assert property (!(psel && penable && pwrite) |=> $stable(state.ctrl_a))
        else $error("control A changed without write");
    stable_nowrite_b_a: assert property (!(psel && penable && pwrite) |=> $stable(state.ctrl_b))
        else $error("control B changed without write");
    stray_write_a: assert property (write_stray_s |=> $stable(state.ctrl_a) && $stable(state.ctrl_b))
        else $error("unmapped write changed a control register");

endmodule : pmd_regs

`default_nettype wire

// ### testbench/tb.sv
// Self-checking testbench for the module disable register bank.
`include "pmd_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
    typedef struct packed {logic [11:0] a; logic [31:0] w; logic [15:0] r; logic [4:0] o;} pmd_row_s;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h3;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    wire logic [4:0] off, en, rn;
    int          errors = 0;
    int          cmp_count = 0;
    pmd_row_s    rows [4] = '{'{`PMD_OFF_CTRL_A, 32'hffffffff, 16'h0482, 5'h1c},
        '{`PMD_OFF_CTRL_B, 32'hffffffff, 16'h000c, 5'h1f}, '{`PMD_OFF_CTRL_A, 32'h0, 16'h0, 5'h03},
        '{`PMD_OFF_CTRL_B, 32'hfffffff7, 16'h0004, 5'h01}};
    always #10 pclk = ~pclk;
    pmd_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comparator_off(off[4]), .crc_engine_off(off[3]), .second_i2c_off(off[2]),
        .ref_clock_out_off(off[1]), .charge_time_unit_off(off[0]), .comparator_clk_en(en[4]),
        .crc_engine_clk_en(en[3]), .second_i2c_clk_en(en[2]), .ref_clock_out_clk_en(en[1]),
        .charge_time_unit_clk_en(en[0]), .comparator_rst_n(rn[4]), .crc_engine_rst_n(rn[3]),
        .second_i2c_rst_n(rn[2]), .ref_clock_out_rst_n(rn[1]), .charge_time_unit_rst_n(rn[0]));
    task automatic stop_test;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_out(input logic [4:0] o);
        logic [4:0] inv;
        inv = ~o;
        chk("off", {27'h0, o}, {27'h0, off});
        chk("clk_en", {27'h0, inv}, {27'h0, en});
        chk("rst_n", {27'h0, inv}, {27'h0, rn});
    endtask : chk_out
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        if (n == 50)
        begin
            errors++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    initial
    begin
        repeat (8) @(posedge pclk);
        chk("rst_n in reset", 32'h0, 32'(rn));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, `PMD_OFF_CTRL_A, 32'h0);
        chk("reset a", 32'h0, rd);
        xfer(1'b0, `PMD_OFF_CTRL_B, 32'h0);
        chk("reset b", 32'h0, rd);
        chk_out(5'h00);
        $display("Test reset done");
        foreach (rows[i])
        begin
            xfer(1'b1, rows[i].a, rows[i].w);
            xfer(1'b0, rows[i].a, 32'h0);
            chk("read", {16'h0, rows[i].r}, rd);
            chk("slverr", 32'h0, 32'(err));
            chk_out(rows[i].o);
        end
        $display("Test table done");
        xfer(1'b1, `PMD_OFF_CTRL_A, 32'hffffffff);
        pstrb <= 4'h1;
        xfer(1'b1, `PMD_OFF_CTRL_A, 32'h0);
        xfer(1'b0, `PMD_OFF_CTRL_A, 32'h0);
        chk("strobe", 32'h0400, rd);
        xfer(1'b1, 12'h008, 32'hffffffff);
        chk("unmapped wr err", 32'h1, 32'(err));
        xfer(1'b0, 12'h008, 32'h0);
        chk("unmapped rd", 32'h0, rd);
        chk("unmapped rd err", 32'h1, 32'(err));
        xfer(1'b0, `PMD_OFF_CTRL_A, 32'h0);
        chk("after unmapped a", 32'h0400, rd);
        xfer(1'b0, `PMD_OFF_CTRL_B, 32'h0);
        chk("after unmapped b", 32'h0004, rd);
        $display("Test strobe and unmapped done");
        presetn <= 1'b0;
        @(posedge pclk);
        chk("rst_n mid reset", 32'h0, {27'h0, rn});
        chk("off mid reset", 32'h0, {27'h0, off});
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, `PMD_OFF_CTRL_A, 32'h0);
        chk("second reset", 32'h0, rd);
        xfer(1'b0, `PMD_OFF_CTRL_B, 32'h0);
        chk("second reset b", 32'h0, rd);
        chk_out(5'h00);
        $display("Test second reset done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
